// ===== core/spi_pkg.sv
package spi_pkg;

    // Register port geometry.
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets on the plain register port.
    localparam logic [2:0] OFS_CTL = 3'h0;
    localparam logic [2:0] OFS_DIV = 3'h1;
    localparam logic [2:0] OFS_TXB = 3'h2;
    localparam logic [2:0] OFS_RXB = 3'h3;
    localparam logic [2:0] OFS_STAT = 3'h4;
    localparam logic [2:0] OFS_MASK = 3'h5;
    localparam logic [2:0] OFS_LIVE = 3'h6;

    // Layout of control_word_zero, bit 5 down to bit 0.
    typedef struct packed {
        logic soft_reset_bit;
        logic master;
        logic four_pin;
        logic enable_pin_mode;
        logic clock_polarity_select;
        logic clock_phase_select;
    } ctl_t;

    // Reset values.
    localparam ctl_t CTL_RST = 6'h20;
    localparam logic [7:0] DIV_RST = 8'h04;
    localparam logic [7:0] MASK_RST = 8'h00;

    // Sticky event bit positions in the status and mask registers.
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_ABORT = 2;
    localparam int EV_W = 3;

    // Bit positions of the live state register.
    localparam int LV_TXFULL = 0;
    localparam int LV_BUSY = 1;
    localparam int LV_WAIT = 2;
    localparam int LV_STE = 3;
    localparam int LV_SCLK = 4;

    // Last bit index of an eight-bit character.
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Synchronised pin levels.
    typedef struct packed {
        logic transmit_enable_pin;
        logic somi;
        logic simo;
        logic sclk;
    } pins_t;

    // Engine states.
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_WAIT_IDLE = 4'h2,
        ST_READY = 4'h4,
        ST_RUN = 4'h8
    } eng_t;

endpackage

// ===== core/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // Two flip-flops per bit; only the second stage is visible.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

// ===== core/spi_unit.sv
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Behaviour
// RL1 - Serial clock idle is low for polarity 0, high for polarity 1.
// RL2 - Slave phase 1 released off-idle must still receive, flag and send bit one.
// RL3 - Slave released off-idle must send the first loaded byte first.
// RL4 - External master parks the clock idle before soft reset clears.
// RL5 - Host should prefer clock phase 0 for the slave.
// RL6 - Host flags failure when transmit flag sets twice without receive flag.
// RL7 - On failure host pulses soft reset and asks the master to resend.
// RL8 - Four-pin master, enable-pin mode 0: enable pin is a conflict input.
// RL9 - Four-pin master, enable-pin mode 1: enable pin drives an enable output.
// RL10 - Mode 0 host writes transmit buffer only while enable input is active.
// RL11 - Conflict mode master aborts a transfer when enable input goes inactive.
// RL12 - After an abort the host rewrites the transmit buffer.
// RL13 - Reset-release hazard concerns slaves with clock phase 1, both variants.
module spi_unit (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic simo_in,
    output logic simo_out,
    output logic simo_oe,
    input wire logic somi_in,
    output logic somi_out,
    output logic somi_oe,
    input wire logic ste_in,
    output logic ste_out,
    output logic ste_oe
);

    logic [3:0] pin_q;
    spi_pkg::pins_t pin_s;
    spi_pkg::ctl_t ctl_r, ctl_nxt;
    logic [7:0] div_r, div_nxt, mask_r, mask_nxt, rdata_r, rdata_nxt;
    logic [7:0] txbuf_r, txbuf_nxt, rxbuf_r, rxbuf_nxt;
    logic tx_full_r, tx_full_nxt;
    logic [spi_pkg::EV_W-1:0] stat_r, stat_nxt, ev;
    spi_pkg::eng_t state_r, state_nxt;
    logic sclk_r, sclk_nxt, out_r, out_nxt, ste_r, ste_nxt, sclk_d_r, sclk_d_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt, div_cnt_r, div_cnt_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic started_r, started_nxt, loaded_r, loaded_nxt, skip_r, skip_nxt;
    logic take_tx, rx_done, abort_ev;
    logic [7:0] rx_word;
    logic pol, pha, tick, sel, ste_ok, conflict_mode;
    logic m_edge, s_edge, lead, trail, sample, shout, in_bit, load;

    // Pins from the far side are resynchronised before use.
    sync2 #(
        .W(4)
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .d({ste_in, somi_in, simo_in, sclk_in}),
        .q(pin_q)
    );

    // Edge classification shared by master and slave paths.
    assign pin_s = spi_pkg::pins_t'(pin_q);
    assign pol = ctl_r.clock_polarity_select;
    assign pha = ctl_r.clock_phase_select;
    assign tick = (div_cnt_r == div_r);
    assign sel = !ctl_r.four_pin || !pin_s.transmit_enable_pin;
    assign conflict_mode = ctl_r.master && ctl_r.four_pin && !ctl_r.enable_pin_mode;
    assign ste_ok = !conflict_mode || pin_s.transmit_enable_pin; // [RL8]
    assign m_edge = (state_r == spi_pkg::ST_RUN) && tick && ste_ok;
    assign s_edge = !ctl_r.master && (state_r == spi_pkg::ST_READY) && sel
        && (pin_s.sclk != sclk_d_r);
    assign lead = m_edge ? (sclk_r == pol) : (s_edge && (sclk_d_r == pol)); // [RL1]
    assign trail = m_edge ? (sclk_r != pol) : (s_edge && (sclk_d_r != pol)); // [RL1]
    assign sample = pha ? trail : lead;
    assign shout = pha ? lead : trail;
    assign in_bit = ctl_r.master ? pin_s.somi : pin_s.simo;
    assign rx_word = {rx_sh_r[6:0], in_bit};

    // Loads the shifter: master on start, slave at a character boundary only.
    always_comb
    begin
        load = 1'b0;
        if (state_r == spi_pkg::ST_READY && tx_full_r)
        begin
            if (ctl_r.master)
                load = ste_ok; // [RL8]
            else
                load = !started_r && !loaded_r && !s_edge; // [RL3]
        end
    end

    // Serial engine next state.
    always_comb
    begin
        state_nxt = state_r;
        sclk_nxt = sclk_r;
        out_nxt = out_r;
        sclk_d_nxt = pin_s.sclk;
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        div_cnt_nxt = div_cnt_r;
        cnt_nxt = cnt_r;
        started_nxt = started_r;
        loaded_nxt = loaded_r;
        skip_nxt = skip_r;
        take_tx = 1'b0;
        rx_done = 1'b0;
        abort_ev = 1'b0;
        unique case (state_r)
            spi_pkg::ST_OFF:
            begin
                if (!ctl_r.soft_reset_bit)
                    state_nxt = ctl_r.master ? spi_pkg::ST_READY : spi_pkg::ST_WAIT_IDLE;
            end
            spi_pkg::ST_WAIT_IDLE:
            begin
                // A slave only arms once the clock sits at its idle level.
                if (pin_s.sclk == pol && sclk_d_r == pol)
                    state_nxt = spi_pkg::ST_READY; // [RL1] [RL2] [RL13]
            end
            spi_pkg::ST_READY:
            begin
                if (ctl_r.master)
                begin
                    sclk_nxt = pol;
                    div_cnt_nxt = 8'h00;
                    if (load)
                    begin
                        state_nxt = spi_pkg::ST_RUN;
                        cnt_nxt = 3'h0;
                        started_nxt = 1'b0;
                        skip_nxt = 1'b0;
                    end
                end
            end
            spi_pkg::ST_RUN:
            begin
                div_cnt_nxt = tick ? 8'h00 : div_cnt_r + 8'h01;
                if (!ste_ok)
                begin
                    // Another master took the bus: drop the character.
                    abort_ev = 1'b1; // [RL11]
                    state_nxt = spi_pkg::ST_READY; // [RL11]
                    sclk_nxt = pol;
                    cnt_nxt = 3'h0;
                    started_nxt = 1'b0;
                    loaded_nxt = 1'b0;
                    skip_nxt = 1'b0;
                end
                else if (m_edge)
                begin
                    sclk_nxt = ~sclk_r;
                    if (trail && (pha ? (cnt_r == spi_pkg::BIT_LAST) : skip_r))
                        state_nxt = spi_pkg::ST_READY;
                end
            end
            default:
            begin
                state_nxt = spi_pkg::ST_OFF;
            end
        endcase
        if (load)
        begin
            take_tx = 1'b1;
            loaded_nxt = 1'b1;
            if (pha)
                tx_sh_nxt = txbuf_r;
            else
            begin
                out_nxt = txbuf_r[7];
                tx_sh_nxt = {txbuf_r[6:0], 1'b0};
            end
        end
        if (lead)
            started_nxt = 1'b1;
        if (shout)
        begin
            // The trailing edge right after a phase-0 boundary must not shift.
            if (skip_r)
                skip_nxt = 1'b0; // [RL3]
            else
            begin
                out_nxt = tx_sh_r[7];
                tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
            end
        end
        if (sample)
        begin
            rx_sh_nxt = rx_word;
            if (cnt_r == spi_pkg::BIT_LAST)
            begin
                rx_done = 1'b1; // [RL2]
                cnt_nxt = 3'h0;
                started_nxt = 1'b0;
                loaded_nxt = 1'b0;
                skip_nxt = !pha;
            end
            else
                cnt_nxt = cnt_r + 3'h1;
        end
        if (ctl_r.soft_reset_bit)
        begin
            state_nxt = spi_pkg::ST_OFF;
            sclk_nxt = pol;
            out_nxt = 1'b0;
            tx_sh_nxt = 8'h00;
            cnt_nxt = 3'h0;
            started_nxt = 1'b0;
            loaded_nxt = 1'b0;
            skip_nxt = 1'b0;
            div_cnt_nxt = 8'h00;
        end
        ste_nxt = (state_nxt != spi_pkg::ST_RUN); // [RL9]
    end

    // Serial engine registers.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_r <= spi_pkg::ST_OFF;
            sclk_r <= 1'b0;
            out_r <= 1'b0;
            ste_r <= 1'b1;
            sclk_d_r <= 1'b0;
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
            div_cnt_r <= 8'h00;
            cnt_r <= 3'h0;
            started_r <= 1'b0;
            loaded_r <= 1'b0;
            skip_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            sclk_r <= sclk_nxt;
            out_r <= out_nxt;
            ste_r <= ste_nxt;
            sclk_d_r <= sclk_d_nxt;
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            div_cnt_r <= div_cnt_nxt;
            cnt_r <= cnt_nxt;
            started_r <= started_nxt;
            loaded_r <= loaded_nxt;
            skip_r <= skip_nxt;
        end
    end

    // Register file next state; a new event wins over a read-clear.
    always_comb
    begin
        ctl_nxt = ctl_r;
        div_nxt = div_r;
        mask_nxt = mask_r;
        txbuf_nxt = txbuf_r;
        rxbuf_nxt = rx_done ? rx_word : rxbuf_r;
        tx_full_nxt = tx_full_r && !take_tx;
        rdata_nxt = 8'h00;
        ev = '0;
        ev[spi_pkg::EV_RX] = rx_done;
        ev[spi_pkg::EV_TX] = take_tx;
        ev[spi_pkg::EV_ABORT] = abort_ev;
        stat_nxt = stat_r | ev;
        if (wr)
        begin
            unique case (addr)
                spi_pkg::OFS_CTL: ctl_nxt = spi_pkg::ctl_t'(wdata[5:0]);
                spi_pkg::OFS_DIV: div_nxt = wdata;
                spi_pkg::OFS_MASK: mask_nxt = wdata;
                spi_pkg::OFS_TXB:
                begin
                    txbuf_nxt = wdata;
                    tx_full_nxt = 1'b1;
                end
                default: ctl_nxt = ctl_r;
            endcase
        end
        if (rd)
        begin
            unique case (addr)
                spi_pkg::OFS_CTL: rdata_nxt = {2'h0, ctl_r};
                spi_pkg::OFS_DIV: rdata_nxt = div_r;
                spi_pkg::OFS_TXB: rdata_nxt = txbuf_r;
                spi_pkg::OFS_RXB: rdata_nxt = rxbuf_r;
                spi_pkg::OFS_MASK: rdata_nxt = mask_r;
                spi_pkg::OFS_STAT:
                begin
                    rdata_nxt = {5'h00, stat_r};
                    stat_nxt = ev;
                end
                spi_pkg::OFS_LIVE:
                begin
                    rdata_nxt[spi_pkg::LV_TXFULL] = tx_full_r;
                    rdata_nxt[spi_pkg::LV_BUSY] = (state_r == spi_pkg::ST_RUN) || started_r;
                    rdata_nxt[spi_pkg::LV_WAIT] = (state_r == spi_pkg::ST_WAIT_IDLE);
                    rdata_nxt[spi_pkg::LV_STE] = pin_s.transmit_enable_pin;
                    rdata_nxt[spi_pkg::LV_SCLK] = pin_s.sclk;
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
        if (ctl_r.soft_reset_bit)
            tx_full_nxt = wr && (addr == spi_pkg::OFS_TXB);
    end

    // Register file flip-flops.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            ctl_r <= spi_pkg::CTL_RST;
            div_r <= spi_pkg::DIV_RST;
            mask_r <= spi_pkg::MASK_RST;
            txbuf_r <= 8'h00;
            rxbuf_r <= 8'h00;
            tx_full_r <= 1'b0;
            stat_r <= '0;
            rdata_r <= 8'h00;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            div_r <= div_nxt;
            mask_r <= mask_nxt;
            txbuf_r <= txbuf_nxt;
            rxbuf_r <= rxbuf_nxt;
            tx_full_r <= tx_full_nxt;
            stat_r <= stat_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Pin drivers and the interrupt level.
    assign rdata = rdata_r;
    assign irq = |(stat_r & mask_r[spi_pkg::EV_W-1:0]);
    assign sclk_out = sclk_r;
    assign sclk_oe = ctl_r.master && !ctl_r.soft_reset_bit;
    assign simo_out = out_r;
    assign simo_oe = ctl_r.master && !ctl_r.soft_reset_bit;
    assign somi_out = out_r;
    assign somi_oe = !ctl_r.master && !ctl_r.soft_reset_bit && sel;
    assign ste_out = ste_r; // [RL9]
    assign ste_oe = ctl_r.master && ctl_r.four_pin && ctl_r.enable_pin_mode; // [RL8] [RL9]

endmodule

// ===== testbench/spi_unit_sva.sv
`timescale 1ns/1ps
module spi_unit_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic simo_oe,
    input wire logic somi_oe,
    input wire logic ste_in,
    input wire logic ste_out,
    input wire logic ste_oe
);
    spi_pkg::ctl_t ctl_r;
    logic cfl;
    // Shadow copy of the control word, taken from bus writes.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            ctl_r <= spi_pkg::CTL_RST;
        else if (wr && addr == spi_pkg::OFS_CTL)
            ctl_r <= spi_pkg::ctl_t'(wdata[5:0]);
    end
    // Conflict-prevention master running out of soft reset.
    assign cfl = ctl_r.master && ctl_r.four_pin && !ctl_r.enable_pin_mode && !ctl_r.soft_reset_bit;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    a_ctl_read: assert property (rd && addr == spi_pkg::OFS_CTL
        |=> rdata == {2'h0, ctl_r})
        else $error("control word read back wrong");
    a_rd_quiet: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_master_oe: assert property (simo_oe == sclk_oe
        && sclk_oe == (ctl_r.master && !ctl_r.soft_reset_bit))
        else $error("master drivers enabled wrongly");
    a_ste_dir: assert property (ste_oe
        == (ctl_r.master && ctl_r.four_pin && ctl_r.enable_pin_mode))
        else $error("enable pin direction wrong");
    a_slave_oe: assert property (somi_oe |-> !ctl_r.master && !ctl_r.soft_reset_bit)
        else $error("slave output driven outside slave mode");
    a_idle_level: assert property (sclk_oe && ste_out && $past(ste_out)
        && ctl_r == $past(ctl_r, 2) |-> sclk_out == ctl_r.clock_polarity_select)
        else $error("master clock not at idle level");
    a_no_start: assert property ((cfl && !ste_in) [*6]
        |-> ste_out && sclk_out == ctl_r.clock_polarity_select)
        else $error("master shifts while enable input inactive");
    a_abort_fast: assert property (cfl && !ste_out && $fell(ste_in) |-> ##[1:6] ste_out)
        else $error("transfer not aborted");
    a_frame_low: assert property (ste_oe && $fell(ste_out) |=> !ste_out [*8])
        else $error("enable output not held for the character");
endmodule

// ===== testbench/spi_far.sv
`timescale 1ns/1ps
module spi_far (
    output logic sclk,
    output logic mosi,
    output logic ss_b,
    input wire logic miso
);
    // Quiet bus: clock parked low, select released.
    initial
    begin
        sclk = 1'b0;
        mosi = 1'b0;
        ss_b = 1'b1;
    end
    // Parks the clock at a chosen level between frames.
    task park(input logic lvl);
        sclk = lvl;
    endtask
    // One character MSB first; clock rests at the polarity level after it.
    task xfer(input logic cpol, input logic cpha, input logic [7:0] tx, output logic [7:0] rx);
        integer k;
        #250 ss_b = 1'b0;
        for (k = 7; k >= 0; k--)
        begin
            if (!cpha)
                mosi = tx[k];
            #62.5 sclk = !cpol;
            if (cpha)
                mosi = tx[k];
            else
                rx[k] = miso;
            #62.5 sclk = cpol;
            if (cpha)
                rx[k] = miso;
        end
        #125 ss_b = 1'b1;
    endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ste_drv = 1'b1;
    logic somi_last = 1'b0;
    logic far_sclk, far_mosi, far_ss_b, irq, sclk_out, sclk_oe, simo_out, simo_oe;
    logic somi_out, somi_oe, ste_out, ste_oe, sclk_w, simo_w, somi_w, ste_w;
    logic [7:0] rdata, v, got, tx;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int i;
    logic [7:0] q[$];
    // Pin levels; a master loops its data back, a released slave line shows the inverse.
    assign sclk_w = sclk_oe ? sclk_out : far_sclk;
    assign simo_w = simo_oe ? simo_out : far_mosi;
    assign somi_w = somi_oe ? somi_out : (sclk_oe ? simo_out : ~somi_last);
    assign ste_w = ste_oe ? ste_out : (sclk_oe ? ste_drv : far_ss_b);
    always #5 mclk = ~mclk;
    // Cycle ceiling and memory of the last slave output.
    always @(posedge mclk)
    begin
        if (somi_oe)
            somi_last <= somi_out;
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    spi_unit spi_unit_inst (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .sclk_in(sclk_w), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .simo_in(simo_w), .simo_out(simo_out), .simo_oe(simo_oe),
        .somi_in(somi_w), .somi_out(somi_out), .somi_oe(somi_oe), .ste_in(ste_w),
        .ste_out(ste_out), .ste_oe(ste_oe));
    spi_far far_inst (.sclk(far_sclk), .mosi(far_mosi), .ss_b(far_ss_b), .miso(somi_w));
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk(input logic [2:0] a, input logic [7:0] e);
        rreg(a, v);
        check(v, e);
    endtask
    task automatic wait_stat(input int b, output logic [7:0] s);
        int n;
        s = 8'h00;
        for (n = 0; n < 300 && s[b] !== 1'b1; n++)
            rreg(spi_pkg::OFS_STAT, s);
        check({7'h00, s[b]}, 8'h01);
    endtask
    task automatic stop_test;
        $display("Errors %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence: reset values, slave release off idle, master modes.
    initial
    begin
        i = $urandom(46);
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        chk(spi_pkg::OFS_CTL, 8'h20);
        chk(spi_pkg::OFS_DIV, 8'h04);
        wreg(3'h7, 8'hFF);
        chk(3'h7, 8'h00);
        chk(spi_pkg::OFS_MASK, 8'h00);
        wreg(spi_pkg::OFS_MASK, 8'h01);
        for (i = 0; i < 4; i++)
        begin
            far_inst.park(!i[1]);
            wreg(spi_pkg::OFS_CTL, {4'h0, i[1], 1'b0, i[1], i[0]});
            tx = 8'($urandom);
            wreg(spi_pkg::OFS_TXB, tx);
            rreg(spi_pkg::OFS_LIVE, v);
            check({7'h00, v[spi_pkg::LV_WAIT]}, 8'h01);
            far_inst.park(i[1]);
            q.push_back(8'($urandom));
            far_inst.xfer(i[1], i[0], q[$], got);
            check(got, tx);
            check({7'h00, irq}, 8'h01);
            wait_stat(spi_pkg::EV_RX, v);
            check({7'h00, irq}, 8'h00);
            check(v & 8'h07, 8'h03);
            chk(spi_pkg::OFS_RXB, q.pop_front());
            wreg(spi_pkg::OFS_CTL, 8'h20);
        end
        wreg(spi_pkg::OFS_DIV, 8'($urandom_range(7, 4)));
        wreg(spi_pkg::OFS_CTL, 8'h1C);
        @(negedge mclk);
        check({7'h00, ste_oe}, 8'h01);
        for (i = 0; i < 2; i++)
        begin
            q.push_back(8'($urandom));
            wreg(spi_pkg::OFS_TXB, q[$]);
        end
        for (i = 0; i < 2; i++)
        begin
            wait_stat(spi_pkg::EV_RX, v);
            chk(spi_pkg::OFS_RXB, q.pop_front());
        end
        ste_drv <= 1'b0;
        wreg(spi_pkg::OFS_CTL, 8'h18);
        wreg(spi_pkg::OFS_TXB, 8'hA5);
        repeat (40) @(posedge mclk);
        rreg(spi_pkg::OFS_LIVE, v);
        check(v & 8'h1B, 8'h01);
        ste_drv <= 1'b1;
        repeat (30) @(posedge mclk);
        ste_drv <= 1'b0;
        wait_stat(spi_pkg::EV_ABORT, v);
        check(v & 8'h05, 8'h04);
        ste_drv <= 1'b1;
        q.push_back(8'($urandom));
        wreg(spi_pkg::OFS_TXB, q[$]);
        wait_stat(spi_pkg::EV_RX, v);
        chk(spi_pkg::OFS_RXB, q.pop_front());
        stop_test();
    end
endmodule
bind spi_unit spi_unit_chk spi_unit_chk_inst (.mclk(mclk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .simo_oe(simo_oe), .somi_oe(somi_oe), .ste_in(ste_in), .ste_out(ste_out), .ste_oe(ste_oe));
